// [src/smd_consts.svh]
// Address windows and widths for the screen memory decoder.
// Assumes a 20-bit processor address and byte-wide data.
`ifndef SMD_CONSTS_SVH
`define SMD_CONSTS_SVH
`define SMD_ADDR_W      20
`define SMD_DATA_W      8
`define SMD_RAM_AW      11
`define SMD_PRI_LO      20'h00030
`define SMD_PRI_HI      20'h007ff
`define SMD_ALI_LO      20'h01030
`define SMD_ALI_HI      20'h017ff
`define SMD_FIFO_DEPTH  8
`define SMD_ROW_CHARS   80
`define SMD_ROW_TIME_US 617
`endif

// [src/smd_pkg.sv]
// Types shared by the screen memory decoder files.
// Assumes smd_consts.svh is on the include path.
`include "smd_consts.svh"
package smd_pkg;
   typedef logic [`SMD_ADDR_W-1:0] smd_addr_t;
   typedef logic [`SMD_DATA_W-1:0] smd_data_t;
   typedef logic [`SMD_RAM_AW-1:0] smd_ram_addr_t;
   typedef enum logic [1:0] {
      SMD_IDLE = 2'b00,
      SMD_BUSY = 2'b01
   } smd_cyc_t;
endpackage : smd_pkg

// [src/smd_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock, active-high asynchronous reset and a clock enable.
`timescale 1ns/1ps
module smd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
      nxt = (p == AW'(DEPTH-1)) ? '0 : AW'(p + 1'b1);
   endfunction : nxt

   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rp_q];

   always_comb begin
      wp_d  = push ? nxt(wp_q) : wp_q;
      rp_d  = pop ? nxt(rp_q) : rp_q;
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = (AW+1)'(cnt_q + 1'b1);
      end else if (pop && !push) begin
         cnt_d = (AW+1)'(cnt_q - 1'b1);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else if (ce) begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage needs no reset; count gates validity
   always_ff @(posedge mclk) begin
      if (ce && push) begin
         mem_q[wp_q] <= in_data;
      end
   end
endmodule : smd_fifo

// [src/smd_decoder.sv]
// Screen memory decoder emulating DMA into the CRT row buffers.
// Assumes a processor bus on mclk, qualified by a per-cycle strobe.
// Operation
// RULE1 - Addresses 30H..7FFH select the screen RAM.
// RULE2 - Addresses 1030H..17FFH select the same screen RAM cells.
// RULE3 - A read in the alias window also strobes a row buffer write.
// RULE4 - One bus cycle moves one byte, read data going to the buffer.
// RULE5 - The processor uses primary addresses for ordinary accesses.
// RULE6 - The processor supplies 80 characters per 617 us row period.
// RULE7 - Outside accesses and alias writes give no row buffer strobe.
`timescale 1ns/1ps
`include "smd_consts.svh"
module smd_decoder #(
   parameter int FIFO_DEPTH = `SMD_FIFO_DEPTH
) (
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire logic                   ce,
   input  wire logic                   bus_cyc,
   input  wire logic                   bus_rd,
   input  wire logic                   bus_wr,
   input  wire smd_pkg::smd_addr_t     bus_addr,
   input  wire smd_pkg::smd_data_t     bus_wdata,
   output      smd_pkg::smd_data_t     bus_rdata_q,
   output      logic                   bus_ack_q,
   output      logic                   ram_sel_q,
   output      logic                   ram_we_q,
   output      smd_pkg::smd_ram_addr_t ram_addr_q,
   output      smd_pkg::smd_data_t     ram_wdata_q,
   input  wire smd_pkg::smd_data_t     ram_rdata,
   output      logic                   row_wr_q,
   output      smd_pkg::smd_data_t     row_data_q,
   input  wire logic                   row_ready
);
   import smd_pkg::*;

   function automatic logic in_win(input smd_addr_t a, input smd_addr_t lo,
                                   input smd_addr_t hi);
      in_win = (a >= lo) && (a <= hi);
   endfunction : in_win

   smd_cyc_t      st_q, st_d;
   logic          pri, ali, hit, alias_rd;
   logic          ram_sel_d, ram_we_d, ack_d, row_wr_d, ali_q, ali_d;
   smd_ram_addr_t ram_addr_d;
   smd_data_t     ram_wdata_d, rdata_d, row_data_d;
   logic          f_in_ready, f_out_valid, f_pop;
   smd_data_t     f_out_data;

   assign pri      = in_win(bus_addr, `SMD_PRI_LO, `SMD_PRI_HI); // [RULE1]
   assign ali      = in_win(bus_addr, `SMD_ALI_LO, `SMD_ALI_HI); // [RULE2]
   assign hit      = pri || ali;
   assign alias_rd = ali && bus_rd; // [RULE3] [RULE7]

   // Cycle engine: select RAM, then answer next edge with RAM data
   always_comb begin
      st_d        = st_q;
      ram_sel_d   = 1'b0;
      ram_we_d    = 1'b0;
      ram_addr_d  = ram_addr_q;
      ram_wdata_d = ram_wdata_q;
      ack_d       = 1'b0;
      rdata_d     = bus_rdata_q;
      ali_d       = ali_q;
      case (st_q)
         SMD_IDLE: begin
            // Alias reads wait for FIFO room so no byte is dropped
            if (bus_cyc && (bus_rd || bus_wr) && !bus_ack_q &&
                (!alias_rd || f_in_ready)) begin
               if (hit) begin
                  ram_sel_d   = 1'b1; // [RULE1] [RULE2]
                  ram_we_d    = bus_wr;
                  // Low 11 bits fold alias onto primary cell
                  ram_addr_d  = bus_addr[`SMD_RAM_AW-1:0]; // [RULE2]
                  ram_wdata_d = bus_wdata;
                  ali_d       = alias_rd;
                  st_d        = SMD_BUSY;
               end else begin
                  ack_d   = 1'b1; // [RULE7]
                  rdata_d = '0;
               end
            end
         end
         SMD_BUSY: begin
            ack_d   = 1'b1;
            rdata_d = ram_rdata;
            st_d    = SMD_IDLE;
         end
         default: st_d = SMD_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q        <= SMD_IDLE;
         ram_sel_q   <= 1'b0;
         ram_we_q    <= 1'b0;
         ram_addr_q  <= '0;
         ram_wdata_q <= '0;
         bus_ack_q   <= 1'b0;
         bus_rdata_q <= '0;
         ali_q       <= 1'b0;
      end else if (ce) begin
         st_q        <= st_d;
         ram_sel_q   <= ram_sel_d;
         ram_we_q    <= ram_we_d;
         ram_addr_q  <= ram_addr_d;
         ram_wdata_q <= ram_wdata_d;
         bus_ack_q   <= ack_d;
         bus_rdata_q <= rdata_d;
         ali_q       <= ali_d;
      end
   end

   // Same byte the RAM returns to the bus enters the row path
   smd_fifo #(.WIDTH(`SMD_DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk      (mclk),
      .rst       (rst),
      .ce        (ce),
      .in_data   (ram_rdata),
      .in_valid  (st_q == SMD_BUSY && ali_q), // [RULE3] [RULE4]
      .in_ready  (f_in_ready),
      .out_data  (f_out_data),
      .out_valid (f_out_valid),
      .out_ready (f_pop)
   );

   // Row strobe is a one-cycle pulse; buffer stalls it via row_ready
   assign f_pop = f_out_valid && row_ready && !row_wr_q;

   always_comb begin
      row_wr_d   = f_pop; // [RULE3] [RULE7]
      row_data_d = f_pop ? f_out_data : row_data_q;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         row_wr_q   <= 1'b0;
         row_data_q <= '0;
      end else if (ce) begin
         row_wr_q   <= row_wr_d;
         row_data_q <= row_data_d;
      end
   end
endmodule : smd_decoder

// [tb/smd_properties.sv]
// Port checker for the screen memory decoder.
// Assumes bound to smd_decoder; ce drops only while a request waits untaken.
`timescale 1ns/1ps
`include "smd_consts.svh"
module smd_properties
   import smd_pkg::*;
(
   input wire logic          mclk,
   input wire logic          rst,
   input wire logic          bus_cyc,
   input wire logic          bus_rd,
   input wire logic          bus_wr,
   input wire smd_addr_t     bus_addr,
   input wire logic          bus_ack_q,
   input wire smd_data_t     bus_rdata_q,
   input wire logic          ram_sel_q,
   input wire smd_ram_addr_t ram_addr_q,
   input wire smd_data_t     ram_rdata,
   input wire logic          row_wr_q
);
   logic       pri, ali;
   logic [4:0] pend_d, pend_q;
   assign pri = bus_addr >= `SMD_PRI_LO && bus_addr <= `SMD_PRI_HI;
   assign ali = bus_addr >= `SMD_ALI_LO && bus_addr <= `SMD_ALI_HI;
   // Bytes read in the alias window not yet strobed out
   always_comb begin
      pend_d = pend_q + 5'(bus_ack_q && bus_rd && ali) - 5'(row_wr_q);
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) pend_q <= 5'h00;
      else pend_q <= pend_d;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_pri_select: assert property (
      $rose(bus_cyc) && pri |=> ram_sel_q && ram_addr_q == bus_addr[10:0])
      else $error("primary miss");
   a_alias_fold: assert property (
      $rose(bus_cyc) && ali && bus_wr |=>
      ram_sel_q && ram_addr_q == bus_addr[10:0])
      else $error("no fold");
   a_alias_strobe: assert property (
      $rose(bus_cyc) && ali && bus_rd |-> ##[2:200] row_wr_q)
      else $error("no row strobe");
   a_read_byte: assert property (
      bus_ack_q && bus_rd && $past(ram_sel_q) |->
      bus_rdata_q == $past(ram_rdata))
      else $error("bad byte");
   a_no_stray: assert property (
      row_wr_q |-> pend_q != 5'h00)
      else $error("stray row strobe");
   a_miss_desel: assert property (
      $rose(bus_cyc) && !pri && !ali |=> !ram_sel_q)
      else $error("miss selected ram");
endmodule : smd_properties
bind smd_decoder smd_properties i_chk (.mclk, .rst, .bus_cyc, .bus_rd,
   .bus_wr, .bus_addr, .bus_ack_q, .bus_rdata_q, .ram_sel_q, .ram_addr_q,
   .ram_rdata, .row_wr_q);

// [tb/smd_ram_model.sv]
// Screen RAM model on the decoder's RAM port.
// Assumes asynchronous read and a write on the select pulse.
`timescale 1ns/1ps
module smd_ram_model
   import smd_pkg::*;
(
   input wire logic          mclk,
   input wire logic          ram_sel_q,
   input wire logic          ram_we_q,
   input wire smd_ram_addr_t ram_addr_q,
   input wire smd_data_t     ram_wdata_q,
   output smd_data_t         ram_rdata
);
   smd_data_t mem [2048];
   initial for (int i = 0; i < 2048; i++) mem[i] = 8'(i) ^ 8'h5a;
   always @(posedge mclk) if (ram_sel_q && ram_we_q) mem[ram_addr_q] <= ram_wdata_q;
   // Unselected RAM shows inverted data so stale bytes never match
   assign ram_rdata = ram_sel_q ? mem[ram_addr_q] : ~mem[ram_addr_q];
endmodule : smd_ram_model

// [tb/smd_decoder_test.sv]
// Self-checking bench for the screen memory decoder.
// Assumes the RAM model answers the RAM port.
`timescale 1ns/1ps
`include "smd_consts.svh"
module smd_decoder_test;
   import smd_pkg::*;
   logic mclk = 1'h0, rst = 1'h1, bus_cyc = 1'h0, bus_rd = 1'h0;
   logic bus_wr = 1'h0, row_ready = 1'h1, bus_ack_q, ram_sel_q, ram_we_q;
   logic row_wr_q, ce = 1'h1;
   smd_addr_t bus_addr = 20'h00000;
   smd_data_t bus_wdata = 8'h00, q, bus_rdata_q, ram_rdata, ram_wdata_q;
   smd_data_t row_data_q, rq[$];
   smd_ram_addr_t ram_addr_q;
   int mismatches = 0, check_count = 0, cyc = 0;
   always #10 mclk = ~mclk;
   always @(posedge mclk) cyc++;
   smd_decoder i_dut (.mclk, .rst, .ce, .bus_cyc, .bus_rd, .bus_wr,
      .bus_addr, .bus_wdata, .bus_rdata_q, .bus_ack_q, .ram_sel_q, .ram_we_q,
      .ram_addr_q, .ram_wdata_q, .ram_rdata, .row_wr_q, .row_data_q,
      .row_ready);
   smd_ram_model i_ram (.mclk, .ram_sel_q, .ram_we_q, .ram_addr_q,
      .ram_wdata_q, .ram_rdata);
   always @(posedge mclk) if (row_wr_q === 1'h1) rq.push_back(row_data_q);
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   task automatic cmp(string n, smd_data_t e, smd_data_t g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : cmp
   task automatic bus_op(logic rd, smd_addr_t a, smd_data_t d);
      int n = 0;
      {bus_cyc, bus_rd, bus_wr, bus_addr, bus_wdata} = {1'h1, rd, !rd, a, d};
      do begin
         @(posedge mclk);
         #1 n++;
      end while (bus_ack_q !== 1'h1 && n < 400);
      if (n >= 400) begin
         mismatches++;
         report_and_stop();
      end
      q = bus_rdata_q;
      bus_cyc = 1'h0;
      @(posedge mclk);
      #1;
   endtask : bus_op
   task automatic rows(int k);
      for (int n = 0; n < 300 && rq.size() < k; n++) @(posedge mclk);
      cmp("rows", 8'(k), 8'(rq.size()));
   endtask : rows
   task automatic t_windows;
      bus_op(1'h0, 20'h00030, 8'hc3);
      bus_op(1'h1, 20'h01030, 8'h00);
      cmp("alias rd", 8'hc3, q);
      bus_op(1'h1, 20'h007ff, 8'h00);
      cmp("pri rd", 8'ha5, q);
      bus_op(1'h0, 20'h017ff, 8'h3c);
      bus_op(1'h1, 20'h007ff, 8'h00);
      cmp("fold wr", 8'h3c, q);
      rows(1);
      cmp("row byte", 8'hc3, rq.pop_front());
   endtask : t_windows
   task automatic t_miss;
      smd_addr_t a[4] = '{20'h0002f, 20'h00800, 20'h0102f, 20'h01800};
      foreach (a[i]) begin
         bus_op(1'h1, a[i], 8'h00);
         cmp("miss rd", 8'h00, q);
      end
      // Give any stray strobe time to surface
      repeat (4) @(posedge mclk);
      rows(0);
   endtask : t_miss
   task automatic t_stall;
      row_ready = 1'h0;
      fork
         begin
            repeat (120) @(posedge mclk);
            cmp("held", 8'h00, 8'(rq.size()));
            #1 row_ready = 1'h1;
         end
         for (int i = 0; i < 10; i++) bus_op(1'h1, 20'h01100 + 20'(i), 8'h00);
      join
      rows(10);
      for (int i = 0; i < 10; i++)
         cmp("row order", 8'(i) ^ 8'h5a, rq.pop_front());
   endtask : t_stall
   task automatic t_hold;
      ce = 1'h0;
      fork
         begin
            repeat (6) @(posedge mclk);
            #1 cmp("frozen", 8'h00, {6'h00, bus_ack_q, ram_sel_q});
            ce = 1'h1;
         end
         bus_op(1'h1, 20'h01040, 8'h00);
      join
      cmp("held rd", 8'h1a, q);
      rows(1);
      cmp("held row", 8'h1a, rq.pop_front());
   endtask : t_hold
   task automatic t_row;
      int t0 = cyc;
      // 50 cycles per microsecond at 20 ns
      int lim = `SMD_ROW_TIME_US * 50;
      for (int i = 0; i < `SMD_ROW_CHARS; i++)
         bus_op(1'h1, 20'h01080 + 20'(i), 8'h00);
      rows(`SMD_ROW_CHARS);
      cmp("row time", 8'h01, 8'(cyc - t0 <= lim));
      for (int i = 0; i < `SMD_ROW_CHARS; i++)
         cmp("row char", 8'(8'h80 + i) ^ 8'h5a, rq.pop_front());
   endtask : t_row
   initial begin
      repeat (4) @(posedge mclk);
      #1 rst = 1'h0;
      t_windows();
      t_miss();
      t_stall();
      t_hold();
      t_row();
      report_and_stop();
   end
endmodule : smd_decoder_test
